/* File: hdl/twd_core.sv */
/*
 twd_core: temperature result and limit registers, configuration byte,
 fault queue and open-drain alarm of the thermal watchdog.
 Assumes a converter front end on sys_clk giving a one-cycle done strobe with
 its 11-bit result, and a serial engine on link_clk giving register strobes.
*/
`timescale 1ns/1ns
`default_nettype none
module twd_core (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        conv_done,
    input  wire logic [10:0] conv_result,
    input  wire logic        link_clk,
    input  wire logic        link_rst,
    input  wire logic [1:0]  link_ptr_sel,
    input  wire logic        link_wr_stb,
    input  wire logic [15:0] link_wr_data,
    input  wire logic        link_rd_stb,
    output var  logic [15:0] link_rd_data,
    output var  logic        link_rd_valid,
    output var  logic        link_busy,
    output var  logic        alarm_output_o,
    output var  logic        alarm_output_oe,
    output var  logic        shutdown_mode,
    output var  logic        alarm_active
);
    twd_xfer_if xfer ();

    twd_link u_link (
        .link_clk (link_clk),
        .link_rst (link_rst),
        .ptr_sel  (link_ptr_sel),
        .wr_stb   (link_wr_stb),
        .wr_data  (link_wr_data),
        .rd_stb   (link_rd_stb),
        .rd_data  (link_rd_data),
        .rd_valid (link_rd_valid),
        .busy     (link_busy),
        .xfer     (xfer.link)
    );

    // registers
    logic [10:0]               temp_q;
    logic [8:0]                over_q;
    logic [8:0]                hyst_q;
    logic [7:0]                conf_q;
    logic [15:0]               rsp_q;
    logic                      ack_tgl_q;
    logic                      req_s1_q;
    logic                      req_s2_q;
    logic                      req_s3_q;
    logic [2:0]                fq_cnt_q;
    logic [2:0]                fq_cnt_d;
    twd_pkg::twd_alarm_state_t state_q;
    twd_pkg::twd_alarm_state_t state_d;
    twd_pkg::twd_alarm_state_t target;

    // decode
    logic        req_edge;
    logic        wr_take;
    logic        rd_take;
    logic        conv_take;
    logic        int_mode;
    logic        pol_high;
    logic [1:0]  fq_field;
    logic [2:0]  fq_need;
    logic [2:0]  cnt_inc;
    logic        queue_full;
    logic [8:0]  new_temp9;
    logic        over_trip;
    logic        under_trip;
    logic        look_over;
    logic        trip_now;
    logic        is_active;
    logic        hold_latched;
    logic        pin_level;
    logic [15:0] rd_mux;
    logic [15:0] temp_word;
    logic [15:0] conf_word;
    logic [15:0] hyst_word;
    logic [15:0] over_word;

    // request toggle arrives from the link domain; fields are stable by then
    assign req_edge  = req_s2_q ^ req_s3_q;
    assign wr_take   = req_edge && xfer.wr;
    assign rd_take   = req_edge && !xfer.wr;
    assign xfer.ack_tgl = ack_tgl_q;
    assign xfer.rdata   = rsp_q;

    // configuration fields
    assign int_mode = conf_q[twd_pkg::CONF_MODE_BIT];
    assign pol_high = conf_q[twd_pkg::CONF_POL_BIT];
    assign fq_field = conf_q[twd_pkg::CONF_FQ_MSB:twd_pkg::CONF_FQ_LSB];

    // no conversions finish while shut down
    assign conv_take = conv_done && !conf_q[twd_pkg::CONF_SHDN_BIT];

    // fault queue length
    assign fq_need = (fq_field == 2'h0) ? twd_pkg::FQ_1 :
                     (fq_field == 2'h1) ? twd_pkg::FQ_2 :
                     (fq_field == 2'h2) ? twd_pkg::FQ_4 :
                                          twd_pkg::FQ_6;
    assign cnt_inc    = fq_cnt_q + 3'h1;
    assign queue_full = (cnt_inc >= fq_need);

    // compare the fresh result, top nine bits, as signed values
    assign new_temp9  = conv_result[twd_pkg::TEMP_W-1:twd_pkg::CMP_LSB];
    assign over_trip  = $signed(new_temp9) > $signed(over_q);
    assign under_trip = $signed(new_temp9) < $signed(hyst_q);

    // which threshold the current state is waiting on
    assign look_over = (state_q == twd_pkg::ALM_WATCH_HIGH) ||
                       ((state_q == twd_pkg::ALM_WATCH_LOW) && !int_mode);
    assign trip_now  = look_over ? over_trip : under_trip;
    assign is_active = (state_q == twd_pkg::ALM_ACTIVE_HIGH) ||
                       (state_q == twd_pkg::ALM_ACTIVE_LOW);
    // latched interrupt holds until a read, whatever the temperature does
    assign hold_latched = int_mode && is_active;

    // open drain: pin level wanted, pulled low when that level is low
    assign pin_level = pol_high ? is_active : !is_active;

    // read words, unused bits zero: low bits of result and limits, high byte of configuration
    assign temp_word = {temp_q, {twd_pkg::TEMP_PAD{1'b0}}};
    assign conf_word = {8'h00, conf_q};
    assign hyst_word = {hyst_q, {twd_pkg::LIM_PAD{1'b0}}};
    assign over_word = {over_q, {twd_pkg::LIM_PAD{1'b0}}};
    assign rd_mux = (xfer.ptr == twd_pkg::PTR_TEMP) ? temp_word :
                    (xfer.ptr == twd_pkg::PTR_CONF) ? conf_word :
                    (xfer.ptr == twd_pkg::PTR_HYST) ? hyst_word :
                                                      over_word;

    // state that the next qualified trip moves to
    always_comb begin
        case (state_q)
            twd_pkg::ALM_WATCH_HIGH: begin
                target = twd_pkg::ALM_ACTIVE_HIGH;
            end
            twd_pkg::ALM_ACTIVE_HIGH: begin
                target = twd_pkg::ALM_WATCH_HIGH;
            end
            twd_pkg::ALM_WATCH_LOW: begin
                target = int_mode ? twd_pkg::ALM_ACTIVE_LOW : twd_pkg::ALM_ACTIVE_HIGH;
            end
            default: begin
                target = twd_pkg::ALM_WATCH_HIGH;
            end
        endcase
    end

    // alarm state and fault queue
    always_comb begin
        state_d  = state_q;
        fq_cnt_d = fq_cnt_q;
        if (conv_take && !hold_latched) begin
            if (trip_now) begin
                if (queue_full) begin
                    state_d  = target;
                    fq_cnt_d = 3'h0;
                end else begin
                    fq_cnt_d = cnt_inc;
                end
            end else begin
                fq_cnt_d = 3'h0;
            end
        end
        // any read clears a latched alarm; comparator mode ignores reads
        if (rd_take && int_mode) begin
            case (state_q)
                twd_pkg::ALM_ACTIVE_HIGH: begin
                    state_d  = twd_pkg::ALM_WATCH_LOW;
                    fq_cnt_d = 3'h0;
                end
                twd_pkg::ALM_ACTIVE_LOW: begin
                    state_d  = twd_pkg::ALM_WATCH_HIGH;
                    fq_cnt_d = 3'h0;
                end
                default: begin
                    state_d  = state_d;
                end
            endcase
        end
    end

    // request synchroniser from the link domain
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else begin
            req_s1_q <= xfer.req_tgl;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    // answer word and its toggle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rsp_q     <= 16'h0000;
            ack_tgl_q <= 1'b0;
        end else if (req_edge) begin
            rsp_q     <= rd_mux;
            ack_tgl_q <= ~ack_tgl_q;
        end
    end

    // result register: only conversions write it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            temp_q <= twd_pkg::TEMP_RST;
        end else if (conv_take) begin
            temp_q <= conv_result;
        end
    end

    // writable registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            conf_q <= twd_pkg::CONF_RST;
            over_q <= twd_pkg::OVER_RST[15:7];
            hyst_q <= twd_pkg::HYST_RST[15:7];
        end else if (wr_take) begin
            if (xfer.ptr == twd_pkg::PTR_CONF) begin
                conf_q <= xfer.wdata[7:0];
            end else if (xfer.ptr == twd_pkg::PTR_HYST) begin
                hyst_q <= xfer.wdata[15:7];
            end else if (xfer.ptr == twd_pkg::PTR_OVER) begin
                over_q <= xfer.wdata[15:7];
            end
        end
    end

    // alarm state machine
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q  <= twd_pkg::ALM_WATCH_HIGH;
            fq_cnt_q <= 3'h0;
        end else begin
            state_q  <= state_d;
            fq_cnt_q <= fq_cnt_d;
        end
    end

    // registered outputs; the pin is never driven high
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            alarm_output_o  <= 1'b0;
            alarm_output_oe <= 1'b0;
            shutdown_mode   <= 1'b0;
            alarm_active    <= 1'b0;
        end else begin
            alarm_output_o  <= 1'b0;
            alarm_output_oe <= !pin_level;
            shutdown_mode   <= conf_q[twd_pkg::CONF_SHDN_BIT];
            alarm_active    <= is_active;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/twd_link.sv */
/*
 twd_link: link-clock front end; turns read and write strobes of the serial
 engine into a toggle handshake towards the core and returns read data.
 Assumes the serial engine gives single-cycle strobes on link_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module twd_link (
    input  wire logic        link_clk,
    input  wire logic        link_rst,
    input  wire logic [1:0]  ptr_sel,
    input  wire logic        wr_stb,
    input  wire logic [15:0] wr_data,
    input  wire logic        rd_stb,
    output var  logic [15:0] rd_data,
    output var  logic        rd_valid,
    output var  logic        busy,
    twd_xfer_if.link         xfer
);
    logic        req_tgl_q;
    logic [1:0]  ptr_q;
    logic        wr_q;
    logic [15:0] wdata_q;
    logic        ack_s1_q;
    logic        ack_s2_q;
    logic        ack_s3_q;
    logic        ack_edge;
    logic        start;

    assign ack_edge      = ack_s2_q ^ ack_s3_q;
    assign start         = !busy && (wr_stb || rd_stb);
    assign xfer.req_tgl  = req_tgl_q;
    assign xfer.ptr      = ptr_q;
    assign xfer.wr       = wr_q;
    assign xfer.wdata    = wdata_q;

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            req_tgl_q <= 1'b0;
            ptr_q     <= 2'h0;
            wr_q      <= 1'b0;
            wdata_q   <= 16'h0000;
            ack_s1_q  <= 1'b0;
            ack_s2_q  <= 1'b0;
            ack_s3_q  <= 1'b0;
            busy      <= 1'b0;
            rd_valid  <= 1'b0;
            rd_data   <= 16'h0000;
        end else begin
            ack_s1_q <= xfer.ack_tgl;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
            rd_valid <= 1'b0;
            if (start) begin
                busy      <= 1'b1;
                req_tgl_q <= ~req_tgl_q;
                ptr_q     <= ptr_sel;
                wr_q      <= wr_stb;
                wdata_q   <= wr_data;
            end else if (busy && ack_edge) begin
                busy     <= 1'b0;
                rd_data  <= xfer.rdata;
                rd_valid <= ~wr_q;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/twd_pkg.sv */
/*
 twd_pkg: constants and types of the thermal watchdog result and alarm block.
 Assumes nothing; used by the core only.
*/
package twd_pkg;
    // pointer values
    localparam logic [1:0] PTR_TEMP = 2'h0;
    localparam logic [1:0] PTR_CONF = 2'h1;
    localparam logic [1:0] PTR_HYST = 2'h2;
    localparam logic [1:0] PTR_OVER = 2'h3;

    // widths of the data held and of the bus word
    localparam int TEMP_W   = 11;
    localparam int LIM_W    = 9;
    localparam int REG_W    = 16;
    localparam int CONF_W   = 8;
    localparam int PTR_W    = 2;
    localparam int TEMP_PAD = 5;
    localparam int LIM_PAD  = 7;
    localparam int CMP_LSB  = 2;

    // configuration field positions
    localparam int CONF_SHDN_BIT = 0;
    localparam int CONF_MODE_BIT = 1;
    localparam int CONF_POL_BIT  = 2;
    localparam int CONF_FQ_LSB   = 3;
    localparam int CONF_FQ_MSB   = 4;

    // reset values
    localparam logic [7:0]  CONF_RST = 8'h00;
    localparam logic [15:0] OVER_RST = 16'h5000;
    localparam logic [15:0] HYST_RST = 16'h4b00;
    localparam logic [10:0] TEMP_RST = 11'h000;

    // fault queue lengths for field values 00, 01, 10, 11
    localparam int          FQ_W = 3;
    localparam logic [2:0]  FQ_1 = 3'h1;
    localparam logic [2:0]  FQ_2 = 3'h2;
    localparam logic [2:0]  FQ_4 = 3'h4;
    localparam logic [2:0]  FQ_6 = 3'h6;

    typedef enum logic [1:0] {
        ALM_WATCH_HIGH,
        ALM_ACTIVE_HIGH,
        ALM_WATCH_LOW,
        ALM_ACTIVE_LOW
    } twd_alarm_state_t;
endpackage

/* File: hdl/twd_xfer_if.sv */
/*
 twd_xfer_if: request and answer signals crossing between the link-side
 front end and the core. Assumes the link end holds ptr, wr and wdata
 steady from its request toggle until the answering toggle returns.
*/
`timescale 1ns/1ns
`default_nettype none
interface twd_xfer_if;
    logic        req_tgl;
    logic [1:0]  ptr;
    logic        wr;
    logic [15:0] wdata;
    logic        ack_tgl;
    logic [15:0] rdata;

    modport link (output req_tgl, output ptr, output wr, output wdata,
                  input ack_tgl, input rdata);
    modport core (input req_tgl, input ptr, input wr, input wdata,
                  output ack_tgl, output rdata);
endinterface
`default_nettype wire

/* File: verif/tb_twd_core.sv */
/*
 tb_twd_core: self-checking bench of the watchdog core.
 Assumes the host model for register access and a pulled-up alarm pin.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_twd_core;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        conv_done = 1'b0;
    logic [10:0] conv_result = 11'h0;
    logic        link_clk = 1'b0;
    logic        link_rst = 1'b1;
    logic [1:0]  link_ptr_sel;
    logic        link_wr_stb;
    logic [15:0] link_wr_data;
    logic        link_rd_stb;
    logic [15:0] link_rd_data;
    logic        link_rd_valid;
    logic        link_busy;
    logic        alarm_output_o;
    logic        alarm_output_oe;
    logic        shutdown_mode;
    logic        alarm_active;
    logic        alarm_pin;
    logic [15:0] rd;
    logic        pol = 1'b0;
    int          n;
    int          bad_count = 0;
    int          samples_checked = 0;
    localparam logic [10:0] HOT  = 11'h0cc;
    localparam logic [10:0] COOL = 11'h09c;

    always #2 sys_clk = ~sys_clk;
    initial begin
        #3;
        forever #40 link_clk = ~link_clk;
    end
    assign alarm_pin = alarm_output_oe ? alarm_output_o : 1'b1;

    twd_core u_twd_core (.sys_clk, .srst, .conv_done, .conv_result, .link_clk, .link_rst,
        .link_ptr_sel, .link_wr_stb, .link_wr_data, .link_rd_stb, .link_rd_data,
        .link_rd_valid, .link_busy, .alarm_output_o, .alarm_output_oe, .shutdown_mode,
        .alarm_active);
    twd_host_model u_twd_host_model (.link_clk, .link_ptr_sel, .link_wr_stb, .link_wr_data,
        .link_rd_stb, .link_rd_data, .link_rd_valid, .link_busy);

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [1:0] p, input logic [15:0] wd);
        logic ok;
        u_twd_host_model.xfer(wr, p, wd, rd, ok);
        if (!ok) begin
            bad_count++;
            $display("ERROR at %0t: access not answered", $time);
            finish_test();
        end
    endtask
    task automatic rdchk(input logic [1:0] p, input logic [15:0] exp);
        acc(1'b0, p, 16'h0);
        chk(rd, exp);
    endtask
    task automatic cfg(input logic [7:0] c);
        acc(1'b1, 2'h1, {8'h00, c});
        pol = c[2];
    endtask
    task automatic conv(input logic [10:0] t, input int k);
        repeat (k) begin
            @(negedge sys_clk);
            conv_done = 1'b1;
            conv_result = t;
            @(negedge sys_clk);
            conv_done = 1'b0;
            conv_result = ~t;
        end
        repeat (3) @(negedge sys_clk);
    endtask
    // pin level is the alarm state seen through the polarity
    task automatic alm(input logic act);
        chk({15'h0, alarm_active}, {15'h0, act});
        chk({15'h0, alarm_output_o}, 16'h0000);
        chk({15'h0, alarm_pin}, {15'h0, act ? pol : !pol});
    endtask

    initial begin
        repeat (20) @(negedge sys_clk);
        srst = 1'b0;
        link_rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        rdchk(2'h3, 16'h5000);
        rdchk(2'h2, 16'h4b00);
        rdchk(2'h1, 16'h0000);
        rdchk(2'h0, 16'h0000);
        alm(1'b0);
        $display("test reset done");
        acc(1'b1, 2'h3, 16'h197f);
        rdchk(2'h3, 16'h1900);
        acc(1'b1, 2'h2, 16'h147f);
        rdchk(2'h2, 16'h1400);
        conv(11'h649, 1);
        rdchk(2'h0, 16'hc920);
        chk({5'h00, rd[15:5]}, {5'h00, 11'h649});
        acc(1'b1, 2'h0, 16'h1234);
        rdchk(2'h0, 16'hc920);
        $display("test registers done");
        conv(11'h0c9, 1);
        alm(1'b0);
        conv(HOT, 1);
        alm(1'b1);
        rdchk(2'h1, 16'h0000);
        alm(1'b1);
        cfg(8'h01);
        chk({15'h0, shutdown_mode}, 16'h0001);
        conv(COOL, 1);
        alm(1'b1);
        cfg(8'h00);
        conv(11'h0a0, 1);
        alm(1'b1);
        conv(COOL, 1);
        alm(1'b0);
        cfg(8'h04);
        alm(1'b0);
        conv(HOT, 1);
        alm(1'b1);
        conv(COOL, 1);
        $display("test comparator done");
        for (int q = 0; q < 4; q++) begin
            n = (q == 0) ? 1 : (q == 1) ? 2 : (q == 2) ? 4 : 6;
            cfg({3'h0, q[1:0], 3'h0});
            conv(HOT, n - 1);
            conv(COOL, 1);
            conv(HOT, n - 1);
            alm(1'b0);
            conv(HOT, 1);
            alm(1'b1);
            conv(COOL, n - 1);
            alm(1'b1);
            conv(COOL, 1);
            alm(1'b0);
        end
        $display("test fault queue done");
        cfg(8'h02);
        conv(HOT, 1);
        alm(1'b1);
        rdchk(2'h0, {HOT, 5'h00});
        alm(1'b0);
        conv(HOT, 1);
        alm(1'b0);
        conv(COOL, 1);
        alm(1'b1);
        acc(1'b0, 2'h1, 16'h0);
        alm(1'b0);
        $display("test interrupt done");
        finish_test();
    end
endmodule
`default_nettype wire

/* File: verif/twd_core_sva.sv */
/*
 twd_core_sva: port-level assertions for the thermal watchdog core.
 Assumes it is bound to twd_core and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module twd_core_sva (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic conv_done,
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic link_wr_stb,
    input wire logic link_rd_stb,
    input wire logic link_rd_valid,
    input wire logic link_busy,
    input wire logic alarm_output_o,
    input wire logic alarm_output_oe,
    input wire logic alarm_active
);
    a_od_low_only: assert property (@(posedge sys_clk) disable iff (srst)
        !alarm_output_o) else $error("alarm data driven high");
    a_rise_after_conv: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(alarm_active) |-> $past(conv_done, 2)) else $error("alarm rose without conversion");
    a_pin_tracks_alarm: assert property (@(posedge sys_clk) disable iff (srst)
        $changed(alarm_active) |-> $changed(alarm_output_oe)) else $error("pin missed alarm");
    a_reset_clears: assert property (@(posedge sys_clk)
        srst |=> !alarm_active && !alarm_output_oe) else $error("reset left alarm on");
    a_busy_on_take: assert property (@(posedge link_clk) disable iff (link_rst)
        (link_rd_stb || link_wr_stb) && !link_busy |=> link_busy) else $error("request not taken");
    a_busy_bounded: assert property (@(posedge link_clk) disable iff (link_rst)
        $rose(link_busy) |-> ##[1:12] !link_busy) else $error("request never answered");
    a_valid_ends_busy: assert property (@(posedge link_clk) disable iff (link_rst)
        link_rd_valid |-> !link_busy && $past(link_busy)) else $error("answer outside request");
    a_valid_one_cycle: assert property (@(posedge link_clk) disable iff (link_rst)
        link_rd_valid |=> !link_rd_valid) else $error("read answer too long");
    c_alarm_set: cover property (@(posedge sys_clk) $rose(alarm_active));
    c_alarm_clr: cover property (@(posedge sys_clk) $fell(alarm_active));
    c_read_done: cover property (@(posedge link_clk) link_rd_valid);
endmodule
bind twd_core twd_core_sva u_twd_core_sva (.sys_clk, .srst, .conv_done, .link_clk, .link_rst,
    .link_wr_stb, .link_rd_stb, .link_rd_valid, .link_busy, .alarm_output_o,
    .alarm_output_oe, .alarm_active);
`default_nettype wire

/* File: verif/twd_host_model.sv */
/*
 twd_host_model: serial host side, one whole register word per transfer.
 Assumes the core's link strobes are sampled on rising link_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module twd_host_model (
    input  wire logic        link_clk,
    output var  logic [1:0]  link_ptr_sel,
    output var  logic        link_wr_stb,
    output var  logic [15:0] link_wr_data,
    output var  logic        link_rd_stb,
    input  wire logic [15:0] link_rd_data,
    input  wire logic        link_rd_valid,
    input  wire logic        link_busy
);
    initial begin
        link_ptr_sel = 2'h0;
        link_wr_stb  = 1'b0;
        link_wr_data = 16'h0;
        link_rd_stb  = 1'b0;
    end
    // strobe held one link cycle, pointer and data kept until busy drops, then scrambled as released
    task automatic xfer(input logic wr, input logic [1:0] p, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok);
        ok = 1'b0;
        rd = 16'h0;
        @(negedge link_clk);
        link_ptr_sel = p;
        link_wr_data = wd;
        link_wr_stb  = wr;
        link_rd_stb  = !wr;
        @(negedge link_clk);
        link_wr_stb = 1'b0;
        link_rd_stb = 1'b0;
        for (int n = 0; n < 20; n++) begin
            @(negedge link_clk);
            if (link_busy === 1'b0) begin
                ok = wr || (link_rd_valid === 1'b1);
                rd = link_rd_data;
                break;
            end
        end
        link_wr_data = ~wd;
        link_ptr_sel = ~p;
    endtask
endmodule
`default_nettype wire
